// >>> pkg/lpe_pkg.sv
// Shared constants, encodings and carrier types of the LED program engines.
package lpe_pkg;
  // ---------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_EXEC = 8'h00;    // Execution control.
  localparam logic [7:0] ADDR_MODE = 8'h01;    // Operation mode.
  localparam logic [7:0] ADDR_PWM_B = 8'h02;   // Direct PWM, blue.
  localparam logic [7:0] ADDR_PWM_G = 8'h03;   // Direct PWM, green.
  localparam logic [7:0] ADDR_PWM_R = 8'h04;   // Direct PWM, red.
  localparam logic [7:0] ADDR_CONFIG = 8'h08;  // Device configuration.
  localparam logic [7:0] ADDR_PC_BASE = 8'h09; // Engine 1 counter.
  localparam logic [7:0] ADDR_PWM_W = 8'h0E;   // Direct PWM, white.
  localparam logic [7:0] ADDR_MAP = 8'h70;     // Output mapping.
  localparam logic [7:0] MEM_BASE = 8'h10;     // Engine 1 program memory.
  localparam logic [7:0] MEM_SPAN = 8'h20;     // Bytes per engine.
  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int NUM_ENG = 3;        // Number of pattern engines.
  localparam int NUM_LED = 4;        // Number of mapped outputs.
  localparam int ENG_FIELD_TOP = 5;  // Top bit of engine 1 field.
  localparam int LOG_EN_BIT = 7;     // Logarithmic scale enable.
  localparam int CHIP_EN_BIT = 6;    // Chip enable.
  localparam int FAST_PWM_BIT = 6;   // Fast PWM rate select.
  localparam logic [7:0] RST_BYTE = 8'h00;  // Reset value of registers.
  localparam logic [1:0] SEL_I2C = 2'h0;    // Output from its own register.
  localparam logic [7:0] OP_SET_PWM = 8'h40; // Upper byte of set-PWM.
  localparam logic [3:0] BIT_COUNT = 4'h8;  // Bits per serial byte.
  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    EXEC_HOLD = 2'h0, EXEC_STEP = 2'h1, EXEC_RUN = 2'h2, EXEC_ONCE = 2'h3
  } lpe_exec_e;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0, MODE_LOAD = 2'h1, MODE_RUN = 2'h2, MODE_DIRECT = 2'h3
  } lpe_mode_e;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_ACK_ADDR = 9'h004,
    ST_REG = 9'h008, ST_ACK_REG = 9'h010, ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040, ST_RDATA = 9'h080, ST_RACK = 9'h100
  } lpe_i2c_e;
  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic en;          // One-cycle register write strobe.
    logic [7:0] addr;  // Register address.
    logic [7:0] data;  // Written byte.
  } lpe_wr_s;
  typedef struct packed {
    logic [7:0] w;  // White output brightness.
    logic [7:0] r;  // Red output brightness.
    logic [7:0] g;  // Green output brightness.
    logic [7:0] b;  // Blue output brightness.
  } lpe_led_s;
endpackage

// >>> core/lpe_engine.sv
// One pattern engine: program memory, program counter and PWM state.
`timescale 1ns/100ps
module lpe_engine #(
  parameter logic [7:0] BASE = 8'h10,  // First memory byte address.
  parameter int DEPTH = 16             // Instructions per engine.
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Control from the register file.
  input wire logic i_tick,
  input wire logic i_freeze,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_exec,
  input wire logic [7:0] i_direct_pwm,
  input wire lpe_pkg::lpe_wr_s i_wr,
  input wire logic i_pc_wr,
  input wire logic [$clog2(DEPTH)-1:0] i_pc_data,
  input wire logic [7:0] i_rd_addr,
  // State towards the register file.
  output logic [$clog2(DEPTH)-1:0] o_pc,
  output logic [7:0] o_rd_data,
  output logic o_hit,
  output logic [7:0] o_pwm,
  output logic o_done,
  output logic o_loading
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PC_ONE = {{(AW-1){1'b0}}, 1'b1};
  logic [15:0] mem_reg [0:DEPTH-1];  // Instruction store.
  logic [AW-1:0] pc_reg;             // Program counter.
  logic [7:0] pwm_reg;               // Brightness set by the program.
  logic done_reg;                    // Single execution finished.
  logic [7:0] wr_off;                // Write offset in this section.
  logic [7:0] rd_off;                // Read offset in this section.
  logic [15:0] instr;                // Instruction at the counter.
  logic wr_ok;                       // Write lands in this section.

  assign wr_off = i_wr.addr - BASE;
  assign rd_off = i_rd_addr - BASE;
  assign wr_ok = i_wr.en && (wr_off < 8'(2 * DEPTH));
  assign o_hit = rd_off < 8'(2 * DEPTH);
  assign instr = mem_reg[pc_reg];
  // Lower address of a slot is the upper byte of the instruction.
  assign o_rd_data = rd_off[0] ? mem_reg[rd_off[AW:1]][7:0]
                               : mem_reg[rd_off[AW:1]][15:8];
  assign o_pc = pc_reg;
  assign o_done = done_reg;
  assign o_loading = (i_mode == lpe_pkg::MODE_LOAD);

  // ---------------------------------------------------------------------
  // Program memory
  // ---------------------------------------------------------------------
  // Writes only land while this engine is loading; others are dropped.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= 16'h0000;
    end
    else if (wr_ok && i_mode == lpe_pkg::MODE_LOAD)
    begin
      if (wr_off[0])
        mem_reg[wr_off[AW:1]][7:0] <= i_wr.data;
      else
        mem_reg[wr_off[AW:1]][15:8] <= i_wr.data;
    end
  end

  // ---------------------------------------------------------------------
  // Execution on the engine clock tick
  // ---------------------------------------------------------------------
  // Each instruction completes within one tick, so hold stops cleanly.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pc_reg <= '0;
      pwm_reg <= lpe_pkg::RST_BYTE;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      // Clearing is not an execution step, so it also runs while frozen.
      // Otherwise a loading engine, which raises the freeze, never clears.
      if (i_tick && i_mode != lpe_pkg::MODE_RUN)
        pc_reg <= '0;
      else if (i_tick && !i_freeze)
      begin
        if (i_exec != lpe_pkg::EXEC_HOLD && instr[15:8] == lpe_pkg::OP_SET_PWM)
          pwm_reg <= instr[7:0];
        // Counter wraps from the last slot to slot zero.
        if (i_exec == lpe_pkg::EXEC_STEP || i_exec == lpe_pkg::EXEC_RUN)
          pc_reg <= pc_reg + PC_ONE;
        if (i_exec == lpe_pkg::EXEC_STEP || i_exec == lpe_pkg::EXEC_ONCE)
          done_reg <= 1'b1;
      end
      else if (i_pc_wr && i_exec == lpe_pkg::EXEC_HOLD)
        pc_reg <= i_pc_data;
    end
  end

  // Disabled forces zero; direct takes the register; else program value.
  always_comb
  begin
    case (i_mode)
      lpe_pkg::MODE_OFF: o_pwm = lpe_pkg::RST_BYTE;
      lpe_pkg::MODE_DIRECT: o_pwm = i_direct_pwm;
      default: o_pwm = pwm_reg;
    endcase
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  pc_clear_a: assert property (i_tick &&
    i_mode != lpe_pkg::MODE_RUN |=> pc_reg == '0)
    else $error("counter not cleared outside run mode");
  pc_step_a: assert property (i_tick && !i_freeze &&
    i_mode == lpe_pkg::MODE_RUN && i_exec == lpe_pkg::EXEC_STEP
    |=> pc_reg == $past(pc_reg) + PC_ONE && done_reg)
    else $error("step did not advance counter once");
  pc_once_a: assert property (i_tick && !i_freeze &&
    i_mode == lpe_pkg::MODE_RUN && i_exec == lpe_pkg::EXEC_ONCE
    |=> $stable(pc_reg) && done_reg)
    else $error("execute-once moved the counter");
  freeze_hold_a: assert property (i_freeze && !i_pc_wr
    |=> $stable(pwm_reg) &&
    ($past(i_mode) != lpe_pkg::MODE_RUN || $stable(pc_reg)))
    else $error("engine moved while loading");
  off_dark_a: assert property (i_mode == lpe_pkg::MODE_OFF
    |-> o_pwm == lpe_pkg::RST_BYTE)
    else $error("disabled engine drives brightness");
endmodule

// >>> core/lpe_ctrl.sv
// Engine controller: serial register port, registers and output mapping.
// Notes on behaviour
// - Three independent engines with own state.
// - Map register selects engine per output.
// - Execution fields at bits 5:4, 3:2, 1:0.
// - Hold finishes current instruction, then stops.
// - Counter accessible only while engine holds.
// - Step executes, advances, returns to hold.
// - Run executes continuously from current counter.
// - Execute-once keeps counter, returns to hold.
// - Mode fields in register 01h per engine.
// - Disabled clears counter, mapped outputs dark.
// - Load mode clears the counter.
// - Run mode follows the execution field.
// - Direct mode clears counter, uses PWM register.
// - Sixteen 16-bit instructions per engine.
// - Address advances after every data byte.
// - Memory at 10h, 30h, 50h sections.
// - Memory writes only to loading engine.
// - Any loading engine freezes all engines.
// - Four-bit counters at 09h, 0Ah, 0Bh.
// - Counter wraps from 15 to 0.
`timescale 1ns/100ps
module lpe_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h30,  // Bus address, arbitrary value.
  parameter int DEPTH = 16                 // Instructions per engine.
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Serial register bus.
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // Engine clock pin.
  input wire logic i_clk_32k,
  // Outputs to the drivers.
  output lpe_pkg::lpe_led_s o_led_pwm,
  output logic o_fast_pwm_rate_select,
  output logic o_log_enable,
  output logic o_chip_enable
);
  localparam int AW = $clog2(DEPTH);
  localparam int NE = lpe_pkg::NUM_ENG;

  // ---------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------
  logic scl_meta, scl_sync, scl_prev;  // Bus clock stages.
  logic sda_meta, sda_sync, sda_prev;  // Bus data stages.
  logic ck_meta, ck_sync, ck_prev;     // Engine clock stages.
  logic scl_rise, scl_fall, bus_start, bus_stop, tick;

  // Two flops before any use; the third stage only feeds edge detection.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
      {ck_meta, ck_sync, ck_prev} <= 3'h0;
    end
    else
    begin
      {scl_meta, scl_sync, scl_prev} <= {i_scl, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {i_sda_in, sda_meta, sda_sync};
      {ck_meta, ck_sync, ck_prev} <= {i_clk_32k, ck_meta, ck_sync};
    end
  end

  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  assign bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;
  // Counter clearing and execution steps only happen on this tick, the rising edge of ck_sync.
  assign tick = ck_sync && !ck_prev;

  // ---------------------------------------------------------------------
  // Serial slave
  // ---------------------------------------------------------------------
  lpe_pkg::lpe_i2c_e st_reg;  // Bus state.
  logic [3:0] cnt_reg;        // Bits seen in this byte.
  logic [7:0] shift_reg;      // Byte being received or sent.
  logic [7:0] ptr_reg;        // Register pointer.
  logic rw_reg;               // Read transaction.
  logic drive_reg;            // Pull the data line low.
  logic [7:0] rd_data;        // Byte at the pointer.
  lpe_pkg::lpe_wr_s wr;       // Write strobe to the registers.

  // One assignment for the whole carrier: strobe, address, data.
  assign wr = {scl_fall && st_reg == lpe_pkg::ST_WDATA &&
               cnt_reg == lpe_pkg::BIT_COUNT, ptr_reg, shift_reg};
  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = !drive_reg;

  // Bits are taken on the rising bus clock and driven after its fall.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_reg <= lpe_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= lpe_pkg::RST_BYTE;
      ptr_reg <= lpe_pkg::RST_BYTE;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else if (bus_start)
    begin
      // A repeated start restarts address phase at any point.
      st_reg <= lpe_pkg::ST_ADDR;
      cnt_reg <= 4'h0;
      drive_reg <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_reg <= lpe_pkg::ST_IDLE;
      drive_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_reg)
        lpe_pkg::ST_ADDR, lpe_pkg::ST_REG, lpe_pkg::ST_WDATA:
        begin
          shift_reg <= {shift_reg[6:0], sda_sync};
          cnt_reg <= cnt_reg + 4'h1;
        end
        lpe_pkg::ST_RDATA: cnt_reg <= cnt_reg + 4'h1;
        // A master that does not acknowledge ends the read.
        lpe_pkg::ST_RACK: if (sda_sync) st_reg <= lpe_pkg::ST_IDLE;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_reg)
        lpe_pkg::ST_ADDR:
          if (cnt_reg == lpe_pkg::BIT_COUNT)
          begin
            // Foreign addresses leave the bus alone until the next start.
            if (shift_reg[7:1] == DEV_ADDR)
            begin
              st_reg <= lpe_pkg::ST_ACK_ADDR;
              rw_reg <= shift_reg[0];
              drive_reg <= 1'b1;
            end
            else
              st_reg <= lpe_pkg::ST_IDLE;
          end
        lpe_pkg::ST_ACK_ADDR:
        begin
          cnt_reg <= 4'h0;
          if (rw_reg)
          begin
            st_reg <= lpe_pkg::ST_RDATA;
            shift_reg <= rd_data;
            drive_reg <= !rd_data[7];
          end
          else
          begin
            st_reg <= lpe_pkg::ST_REG;
            drive_reg <= 1'b0;
          end
        end
        lpe_pkg::ST_REG:
          if (cnt_reg == lpe_pkg::BIT_COUNT)
          begin
            ptr_reg <= shift_reg;
            st_reg <= lpe_pkg::ST_ACK_REG;
            drive_reg <= 1'b1;
          end
        lpe_pkg::ST_WDATA:
          if (cnt_reg == lpe_pkg::BIT_COUNT)
          begin
            ptr_reg <= ptr_reg + 8'h01;
            st_reg <= lpe_pkg::ST_ACK_W;
            drive_reg <= 1'b1;
          end
        lpe_pkg::ST_ACK_REG, lpe_pkg::ST_ACK_W:
        begin
          st_reg <= lpe_pkg::ST_WDATA;
          cnt_reg <= 4'h0;
          drive_reg <= 1'b0;
        end
        lpe_pkg::ST_RDATA:
          if (cnt_reg == lpe_pkg::BIT_COUNT)
          begin
            ptr_reg <= ptr_reg + 8'h01;
            st_reg <= lpe_pkg::ST_RACK;
            drive_reg <= 1'b0;
          end
          else
          begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            drive_reg <= !shift_reg[6];
          end
        lpe_pkg::ST_RACK:
        begin
          st_reg <= lpe_pkg::ST_RDATA;
          cnt_reg <= 4'h0;
          shift_reg <= rd_data;
          drive_reg <= !rd_data[7];
        end
        default: st_reg <= lpe_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  logic [7:0] exec_reg;    // Execution control.
  logic [7:0] mode_reg;    // Operation mode.
  logic [7:0] config_reg;  // Device configuration.
  logic [7:0] map_reg;     // Output mapping.
  logic [7:0] dpwm_reg [0:lpe_pkg::NUM_LED-1];  // Direct PWM b, g, r, w.
  logic [NE-1:0] done;     // Engine finished a single execution.
  logic [NE-1:0] loading;  // Engine is loading.
  logic freeze;            // Some engine is loading.

  // Host writes; a finished step or execute-once drops its field to hold.
  // A host write in the same cycle wins, since it is the newer command.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      exec_reg <= lpe_pkg::RST_BYTE;
    else if (wr.en && wr.addr == lpe_pkg::ADDR_EXEC)
      exec_reg <= wr.data;
    else
    begin
      for (int e = 0; e < NE; e++)
        if (done[e])
          exec_reg[lpe_pkg::ENG_FIELD_TOP-2*e -: 2] <= 2'h0;
    end
  end

  // Plain configuration registers.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mode_reg <= lpe_pkg::RST_BYTE;
      config_reg <= lpe_pkg::RST_BYTE;
      map_reg <= lpe_pkg::RST_BYTE;
      for (int k = 0; k < lpe_pkg::NUM_LED; k++)
        dpwm_reg[k] <= lpe_pkg::RST_BYTE;
    end
    else if (wr.en)
    begin
      case (wr.addr)
        lpe_pkg::ADDR_MODE: mode_reg <= wr.data;
        lpe_pkg::ADDR_CONFIG: config_reg <= wr.data;
        lpe_pkg::ADDR_MAP: map_reg <= wr.data;
        lpe_pkg::ADDR_PWM_B: dpwm_reg[0] <= wr.data;
        lpe_pkg::ADDR_PWM_G: dpwm_reg[1] <= wr.data;
        lpe_pkg::ADDR_PWM_R: dpwm_reg[2] <= wr.data;
        lpe_pkg::ADDR_PWM_W: dpwm_reg[3] <= wr.data;
        default: ;
      endcase
    end
  end

  assign freeze = |loading;
  assign o_fast_pwm_rate_select = config_reg[lpe_pkg::FAST_PWM_BIT];
  assign o_log_enable = exec_reg[lpe_pkg::LOG_EN_BIT];
  assign o_chip_enable = exec_reg[lpe_pkg::CHIP_EN_BIT];

  // ---------------------------------------------------------------------
  // Engines
  // ---------------------------------------------------------------------
  logic [AW-1:0] eng_pc [0:NE-1];
  logic [7:0] eng_rd [0:NE-1];
  logic [7:0] eng_pwm [0:NE-1];
  logic [NE-1:0] eng_hit;

  // Engine e owns its memory section, counter address and direct PWM.
  for (genvar e = 0; e < NE; e++)
  begin : g_eng
    lpe_engine #(
      .BASE(8'(lpe_pkg::MEM_BASE + e * lpe_pkg::MEM_SPAN)),
      .DEPTH(DEPTH)
    ) u_engine (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_tick(tick),
      .i_freeze(freeze),
      .i_mode(mode_reg[lpe_pkg::ENG_FIELD_TOP-2*e -: 2]),
      .i_exec(exec_reg[lpe_pkg::ENG_FIELD_TOP-2*e -: 2]),
      .i_direct_pwm(dpwm_reg[e]),
      .i_wr(wr),
      .i_pc_wr(wr.en && wr.addr == 8'(lpe_pkg::ADDR_PC_BASE + e)),
      .i_pc_data(wr.data[AW-1:0]),
      .i_rd_addr(ptr_reg),
      .o_pc(eng_pc[e]),
      .o_rd_data(eng_rd[e]),
      .o_hit(eng_hit[e]),
      .o_pwm(eng_pwm[e]),
      .o_done(done[e]),
      .o_loading(loading[e])
    );
  end

  // ---------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------
  // Counters read as zero unless their engine holds; unmapped reads zero.
  always_comb
  begin
    rd_data = lpe_pkg::RST_BYTE;
    case (ptr_reg)
      lpe_pkg::ADDR_EXEC: rd_data = exec_reg;
      lpe_pkg::ADDR_MODE: rd_data = mode_reg;
      lpe_pkg::ADDR_CONFIG: rd_data = config_reg;
      lpe_pkg::ADDR_MAP: rd_data = map_reg;
      lpe_pkg::ADDR_PWM_B: rd_data = dpwm_reg[0];
      lpe_pkg::ADDR_PWM_G: rd_data = dpwm_reg[1];
      lpe_pkg::ADDR_PWM_R: rd_data = dpwm_reg[2];
      lpe_pkg::ADDR_PWM_W: rd_data = dpwm_reg[3];
      default:
        for (int e = 0; e < NE; e++)
        begin
          if (ptr_reg == 8'(lpe_pkg::ADDR_PC_BASE + e) &&
              exec_reg[lpe_pkg::ENG_FIELD_TOP-2*e -: 2] == 2'h0)
            rd_data = 8'(eng_pc[e]);
          if (eng_hit[e])
            rd_data = eng_rd[e];
        end
    endcase
  end

  // ---------------------------------------------------------------------
  // Output mapping
  // ---------------------------------------------------------------------
  // Registered so the driver sees one clean value per cycle.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_led_pwm <= '0;
    else
    begin
      for (int k = 0; k < lpe_pkg::NUM_LED; k++)
        if (map_reg[2*k+1 -: 2] == lpe_pkg::SEL_I2C)
          o_led_pwm[8*k +: 8] <= dpwm_reg[k];
        else
          o_led_pwm[8*k +: 8] <= eng_pwm[map_reg[2*k+1 -: 2] - 2'h1];
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_step_done;
    done[0] && !(wr.en && wr.addr == lpe_pkg::ADDR_EXEC);
  endsequence
  exec_return_a: assert property (s_step_done
    |=> exec_reg[lpe_pkg::ENG_FIELD_TOP -: 2] == 2'h0)
    else $error("engine field did not return to hold");
  map_blue_a: assert property (map_reg[1:0] == 2'h1
    && $stable(map_reg) |=> o_led_pwm.b == $past(eng_pwm[0]))
    else $error("blue output not taken from engine 1");
  byte_adv_a: assert property (wr.en
    |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("address did not advance after a byte");
endmodule

// >>> testbench/lpe_host.sv
// Serial bus master model that writes and reads controller registers.
`timescale 1ns/100ps
module lpe_host (
  // Clock and resolved data wire.
  input wire logic i_ref_clk,
  input wire logic i_sda,
  // Bus pins and read results.
  output logic o_scl,
  output logic o_pull,
  output logic o_rd_stb,
  output logic [7:0] o_rd_byte
);
  initial
  begin
    o_scl = 1'b1;
    o_pull = 1'b0;
    o_rd_stb = 1'b0;
    o_rd_byte = 8'h00;
  end
  task automatic wt();
    repeat (25) @(posedge i_ref_clk);
  endtask
  // Data moves only while the clock is low; sampled at the high phase.
  task automatic bit_io(input logic b, output logic s);
    o_pull <= !b;
    wt();
    o_scl <= 1'b1;
    wt();
    s = i_sda;
    o_scl <= 1'b0;
    wt();
  endtask
  // Also serves a repeated start, since it releases the wire first.
  task automatic start();
    o_pull <= 1'b0;
    wt();
    o_scl <= 1'b1;
    wt();
    o_pull <= 1'b1;
    wt();
    o_scl <= 1'b0;
    wt();
  endtask
  task automatic stop();
    o_pull <= 1'b1;
    wt();
    o_scl <= 1'b1;
    wt();
    o_pull <= 1'b0;
    wt();
  endtask
  // Eight bits MSB first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], s);
      r[i] = s;
    end
    bit_io(last, s);
  endtask
  task automatic put(input logic [7:0] p, input logic [15:0] d,
                     input logic two);
    logic [7:0] r;
    start();
    xfer(8'h60, 1'b1, r);
    xfer(p, 1'b1, r);
    if (two)
      xfer(d[15:8], 1'b1, r);
    xfer(d[7:0], 1'b1, r);
    stop();
  endtask
  task automatic get(input logic [7:0] p);
    logic [7:0] r;
    start();
    xfer(8'h60, 1'b1, r);
    xfer(p, 1'b1, r);
    start();
    xfer(8'h61, 1'b1, r);
    xfer(8'hFF, 1'b1, r);
    stop();
    o_rd_byte <= r;
    o_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    o_rd_stb <= 1'b0;
  endtask
endmodule

// >>> testbench/lpe_ctrl_bench.sv
// Self-checking bench of the engine controller.
`timescale 1ns/100ps
module lpe_ctrl_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic k32 = 1'b0;
  logic scl, pull, stb, sda_out, oe_n, sda;
  logic [7:0] rb, r1, r2;
  lpe_pkg::lpe_led_s led;
  logic led_stb = 1'b0;
  logic [31:0] q[$];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  // Open-drain wire: low when either party pulls.
  assign sda = !pull && (oe_n || sda_out);
  lpe_ctrl u_lpe_ctrl (.i_ref_clk(clk), .i_nrst(nrst), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .i_clk_32k(k32),
    .o_led_pwm(led), .o_fast_pwm_rate_select(), .o_log_enable(),
    .o_chip_enable());
  lpe_host u_lpe_host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_pull(pull), .o_rd_stb(stb), .o_rd_byte(rb));
  initial
    forever #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Engine clock of 80 ns period, plus the hang limit.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0)
      k32 <= !k32;
    if (cyc == 60000)
    begin
      fails++;
      conclude();
    end
  end
  // Oldest note is compared whenever a result shows up.
  always @(posedge clk)
  begin
    if (stb)
      check({24'h0, rb}, q.pop_front());
    if (led_stb)
      check(led, q.pop_front());
  end
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    q.push_back({24'h0, e});
    u_lpe_host.get(p);
  endtask
  // Wait several engine ticks before sampling the outputs.
  task automatic ledx(input logic [31:0] e);
    repeat (40) @(posedge clk);
    q.push_back(e);
    led_stb <= 1'b1;
    @(posedge clk);
    led_stb <= 1'b0;
  endtask
  initial
  begin
    void'($urandom(32'h46EF));
    r1 = 8'($urandom());
    r2 = 8'($urandom());
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    u_lpe_host.put(8'h02, {r1, r2}, 1'b1);
    u_lpe_host.put(8'h70, 16'h09, 1'b0);
    u_lpe_host.put(8'h01, 16'h3C, 1'b0);
    ledx({16'h0, r2, r1});
    rd(8'h70, 8'h09);
    u_lpe_host.put(8'h01, 16'h0C, 1'b0);
    ledx({16'h0, r2, 8'h00});
    u_lpe_host.put(8'h01, 16'h1C, 1'b0);
    u_lpe_host.put(8'h30, 16'h40AB, 1'b1);
    rd(8'h30, 8'h00);
    u_lpe_host.put(8'h10, 16'h40AB, 1'b1);
    u_lpe_host.put(8'h12, {8'h40, r1}, 1'b1);
    rd(8'h11, 8'hAB);
    u_lpe_host.put(8'h01, 16'h2C, 1'b0);
    u_lpe_host.put(8'h00, 16'h10, 1'b0);
    ledx({16'h0, r2, 8'hAB});
    rd(8'h00, 8'h00);
    rd(8'h09, 8'h01);
    u_lpe_host.put(8'h00, 16'h30, 1'b0);
    ledx({16'h0, r2, r1});
    rd(8'h00, 8'h00);
    rd(8'h09, 8'h01);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
